// ---- hw/wdog_pkg.sv ----
// Shared constants and types for the program flow watchdog.
package wdog_pkg;

  // Register byte offsets on the APB slave.
  localparam logic [7:0] OPTIONS_OFFS    = 8'h00;
  localparam logic [7:0] CAUSE_OFFS      = 8'h04;
  localparam logic [7:0] INT_STATUS_OFFS = 8'h08;
  localparam logic [7:0] INT_MASK_OFFS   = 8'h0C;
  localparam logic [7:0] COUNT_OFFS      = 8'h10;

  // Field positions of system_options_one.
  localparam int OPT_EN_BIT    = 0;
  localparam int OPT_CLK_BIT   = 1;
  localparam int OPT_TSEL_LSB  = 2;
  localparam int OPT_LOCK_BIT  = 7;

  // Field positions of reset_cause_status and of the interrupt registers.
  localparam int CAUSE_WDOG_BIT = 0;
  localparam int EV_SERVICE_BIT = 0;
  localparam int EV_WARN_BIT    = 1;
  localparam int EV_W           = 2;

  // Reset values.
  localparam logic       OPT_EN_RST   = 1'b1;
  localparam logic       OPT_CLK_RST  = 1'b0;
  localparam logic [2:0] OPT_TSEL_RST = 3'h7;
  localparam logic [1:0] INT_MASK_RST = 2'h0;

  // Clock source codes.
  localparam logic CLK_SEL_LFO = 1'b0;
  localparam logic CLK_SEL_BUS = 1'b1;

  // Overflow exponents: count = 2 ** exponent.
  localparam logic [4:0] LFO_EXP_BASE = 5'h05;
  localparam logic [4:0] LFO_EXP_MAX  = 5'h0B;
  localparam logic [2:0] LFO_TSEL_CAP = 3'h5;
  localparam logic [4:0] BUS_EXP_BASE = 5'h0D;
  localparam logic [4:0] BUS_EXP_MAX  = 5'h13;
  localparam logic [2:0] BUS_TSEL_CAP = 3'h6;

  // Counter must hold the largest overflow count minus one.
  localparam int CNT_W_MIN = 19;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_COUNT = 3'b010,
    ST_FIRED = 3'b100
  } wdog_state_type;

endpackage

// ---- hw/tick_edge.sv ----
// Rising edge detector that turns a tick level into a one-cycle pulse.
module tick_edge (
  input  wire logic clk_sys,
  input  wire logic srst,
  input  wire logic level,
  output logic      pulse
);

  logic level_q;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      level_q <= 1'b0;
    end else begin
      level_q <= level;
    end
  end

  // A tick that is already high at reset release counts once.
  assign pulse = level & ~level_q;

endmodule // tick_edge

// ---- hw/program_flow_watchdog.sv ----
// Program flow watchdog with APB register access and system reset request.
module program_flow_watchdog #(
  parameter int CNT_W = 19
) (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        power_on_rst,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        lfo_tick,
  input  wire logic        bus_tick,
  input  wire logic        bdm_active,
  output logic             wdog_reset,
  output logic             irq
);

  generate
    if (CNT_W < wdog_pkg::CNT_W_MIN) begin : g_bad_width
      $error("Counter width too small for the longest overflow count.");
    end
  endgenerate

  // Register state.
  logic                      opt_en_q;
  logic                      opt_clk_q;
  logic [2:0]                opt_tsel_q;
  logic                      opt_lock_q;
  logic                      cause_q;
  logic                      srst_q;
  logic [wdog_pkg::EV_W-1:0] int_status_q;
  logic [wdog_pkg::EV_W-1:0] int_status_d;
  logic [wdog_pkg::EV_W-1:0] int_mask_q;
  logic [CNT_W-1:0]          count_q;
  logic [CNT_W-1:0]          count_d;
  logic [31:0]               prdata_q;
  logic                      pslverr_q;
  wdog_pkg::wdog_state_type  state_q;
  wdog_pkg::wdog_state_type  state_d;

  // Bus decode.
  wire        setup_ph   = psel & ~penable;
  wire        access_ph  = psel & penable;
  wire        wr_access  = access_ph & pwrite;
  wire        hit_opt    = (paddr == wdog_pkg::OPTIONS_OFFS);
  wire        hit_cause  = (paddr == wdog_pkg::CAUSE_OFFS);
  wire        hit_status = (paddr == wdog_pkg::INT_STATUS_OFFS);
  wire        hit_mask   = (paddr == wdog_pkg::INT_MASK_OFFS);
  wire        hit_count  = (paddr == wdog_pkg::COUNT_OFFS);
  wire        mapped     = hit_opt | hit_cause | hit_status | hit_mask | hit_count;
  wire        opt_wr     = wr_access & hit_opt & ~opt_lock_q;
  wire        service    = wr_access & hit_cause;
  wire        status_wr  = wr_access & hit_status;
  wire        mask_wr    = wr_access & hit_mask;

  // Read data assembly; unused bits read as zero.
  wire [31:0] opt_word   = {24'h0, opt_lock_q, 2'h0, opt_tsel_q, opt_clk_q, opt_en_q};
  wire [31:0] cause_word = {31'h0, cause_q};
  wire [31:0] stat_word  = {30'h0, int_status_q};
  wire [31:0] mask_word  = {30'h0, int_mask_q};
  wire [31:0] count_word = 32'(count_q);
  wire [31:0] rd_mux     = hit_opt    ? opt_word   :
                           hit_cause  ? cause_word :
                           hit_status ? stat_word  :
                           hit_mask   ? mask_word  :
                           hit_count  ? count_word : 32'h0;

  // Overflow selection.
  wire [4:0] lfo_exp = (opt_tsel_q > wdog_pkg::LFO_TSEL_CAP) ? wdog_pkg::LFO_EXP_MAX :
                       wdog_pkg::LFO_EXP_BASE + {2'h0, opt_tsel_q};
  wire [4:0] bus_exp = (opt_tsel_q > wdog_pkg::BUS_TSEL_CAP) ? wdog_pkg::BUS_EXP_MAX :
                       wdog_pkg::BUS_EXP_BASE + {2'h0, opt_tsel_q};
  wire [4:0] ovf_exp = (opt_clk_q == wdog_pkg::CLK_SEL_BUS) ? bus_exp : lfo_exp;
  wire [CNT_W-1:0] count_last = {CNT_W{1'b1}} >> (CNT_W - int'(ovf_exp));
  wire [CNT_W-1:0] count_half = count_last >> 1;

  // Tick pulses from both sources.
  logic lfo_pulse;
  logic bus_pulse;

  tick_edge u_lfo_edge (
    .clk_sys (clk_sys),
    .srst    (srst),
    .level   (lfo_tick),
    .pulse   (lfo_pulse)
  );

  tick_edge u_bus_edge (
    .clk_sys (clk_sys),
    .srst    (srst),
    .level   (bus_tick),
    .pulse   (bus_pulse)
  );

  wire tick     = (opt_clk_q == wdog_pkg::CLK_SEL_BUS) ? bus_pulse : lfo_pulse;
  wire run      = (state_q == wdog_pkg::ST_COUNT) & ~bdm_active;
  wire step     = run & tick;
  wire overflow = step & (count_q == count_last) & ~service;
  wire warn     = step & (count_q == count_half) & ~service;

  // Service wins over an overflow in the same cycle, the kinder outcome.
  always_comb begin
    count_d = count_q;
    if (service || overflow) begin
      count_d = '0;
    end else if (step) begin
      count_d = count_q + CNT_W'(1);
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      wdog_pkg::ST_IDLE: begin
        if (opt_en_q) begin
          state_d = wdog_pkg::ST_COUNT;
        end
      end
      wdog_pkg::ST_COUNT: begin
        if (overflow) begin
          state_d = wdog_pkg::ST_FIRED;
        end else if (!opt_en_q) begin
          state_d = wdog_pkg::ST_IDLE;
        end
      end
      wdog_pkg::ST_FIRED: begin
        state_d = wdog_pkg::ST_FIRED;
      end
      default: begin
        state_d = wdog_pkg::ST_COUNT;
      end
    endcase
  end

  // Hardware set wins over a write-one-to-clear in the same cycle.
  assign int_status_d = (int_status_q & ~(status_wr ? pwdata[wdog_pkg::EV_W-1:0] : '0))
                      | {warn, service};

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_q <= wdog_pkg::ST_COUNT;
      count_q <= '0;
    end else begin
      state_q <= state_d;
      count_q <= count_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      opt_en_q   <= wdog_pkg::OPT_EN_RST;
      opt_clk_q  <= wdog_pkg::OPT_CLK_RST;
      opt_tsel_q <= wdog_pkg::OPT_TSEL_RST;
      opt_lock_q <= 1'b0;
    end else if (opt_wr) begin
      opt_en_q   <= pwdata[wdog_pkg::OPT_EN_BIT];
      opt_clk_q  <= pwdata[wdog_pkg::OPT_CLK_BIT];
      opt_tsel_q <= pwdata[wdog_pkg::OPT_TSEL_LSB +: 3];
      opt_lock_q <= 1'b1;
    end
  end

  // The cause bit survives a system reset so software can read why it restarted.
  // Only a power-on reset clears it outright. Bus writes never touch it.
  // It is taken on the first reset edge only; by the second edge the state is already back to counting.
  always_ff @(posedge clk_sys) begin
    srst_q <= srst;
  end

  wire reset_entry = srst & ~srst_q;

  always_ff @(posedge clk_sys) begin
    if (srst && power_on_rst) begin
      cause_q <= 1'b0;
    end else if (reset_entry) begin
      cause_q <= (state_q == wdog_pkg::ST_FIRED);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      int_status_q <= '0;
      int_mask_q   <= wdog_pkg::INT_MASK_RST;
    end else begin
      int_status_q <= int_status_d;
      if (mask_wr) begin
        int_mask_q <= pwdata[wdog_pkg::EV_W-1:0];
      end
    end
  end

  // Read data is captured in the setup cycle, so zero wait states still give registered data.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      prdata_q  <= 32'h0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q  <= setup_ph ? rd_mux : prdata_q;
      pslverr_q <= setup_ph & ~mapped;
    end
  end

  assign prdata     = prdata_q;
  assign pslverr    = pslverr_q & access_ph;
  assign pready     = 1'b1;
  assign wdog_reset = (state_q == wdog_pkg::ST_FIRED);
  assign irq        = |(int_status_q & int_mask_q);

  // Checks.
  property p_overflow_fires;
    @(posedge clk_sys) disable iff (srst)
      overflow |=> wdog_reset && (count_q == '0);
  endproperty
  a_overflow_fires: assert property (p_overflow_fires) else $error("Overflow did not raise reset.");

  property p_fired_holds;
    @(posedge clk_sys) disable iff (srst)
      wdog_reset |=> wdog_reset [*3];
  endproperty
  a_fired_holds: assert property (p_fired_holds) else $error("Reset request dropped before system reset.");

  property p_service_clears;
    @(posedge clk_sys) disable iff (srst)
      service |=> (count_q == '0) && !wdog_reset;
  endproperty
  a_service_clears: assert property (p_service_clears) else $error("Service write did not clear counter.");

  property p_service_keeps_cause;
    @(posedge clk_sys) disable iff (srst)
      service |=> $stable(cause_q);
  endproperty
  a_service_keeps_cause: assert property (p_service_keeps_cause) else $error("Service write changed cause.");

  property p_tick_source;
    @(posedge clk_sys) disable iff (srst)
      run && !service && (count_q != count_last) && (opt_clk_q ? bus_pulse : lfo_pulse)
        |=> count_q == $past(count_q) + CNT_W'(1);
  endproperty
  a_tick_source: assert property (p_tick_source) else $error("Selected tick did not advance counter.");

  property p_lfo_cap;
    @(posedge clk_sys) disable iff (srst)
      (opt_clk_q == wdog_pkg::CLK_SEL_LFO) && (opt_tsel_q == 3'h6) |-> count_last == CNT_W'(2047);
  endproperty
  a_lfo_cap: assert property (p_lfo_cap) else $error("Low frequency overflow count wrong.");

  property p_lfo_base;
    @(posedge clk_sys) disable iff (srst)
      (opt_clk_q == wdog_pkg::CLK_SEL_LFO) && (opt_tsel_q == 3'h0) |-> count_last == CNT_W'(31);
  endproperty
  a_lfo_base: assert property (p_lfo_base) else $error("Shortest low frequency count wrong.");

  property p_bus_cap;
    @(posedge clk_sys) disable iff (srst)
      (opt_clk_q == wdog_pkg::CLK_SEL_BUS) && (opt_tsel_q == 3'h7) |-> count_last == CNT_W'(524287);
  endproperty
  a_bus_cap: assert property (p_bus_cap) else $error("Bus clock overflow count wrong.");

  property p_reset_defaults;
    @(posedge clk_sys)
      srst |=> opt_en_q && !opt_lock_q && (count_q == '0) && (state_q == wdog_pkg::ST_COUNT);
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("Reset did not restore enabled watchdog.");

  property p_write_once;
    @(posedge clk_sys) disable iff (srst)
      opt_lock_q |=> $stable(opt_en_q) && $stable(opt_clk_q) && $stable(opt_tsel_q);
  endproperty
  a_write_once: assert property (p_write_once) else $error("Locked options changed.");

  property p_debug_pause;
    @(posedge clk_sys) disable iff (srst)
      bdm_active && !service |=> $stable(count_q) && !$rose(wdog_reset);
  endproperty
  a_debug_pause: assert property (p_debug_pause) else $error("Counter moved during debug.");

  property p_cause_set;
    @(posedge clk_sys)
      srst && !power_on_rst && wdog_reset |=> cause_q && !wdog_reset;
  endproperty
  a_cause_set: assert property (p_cause_set) else $error("Watchdog reset not recorded.");

  property p_reset_clears_count;
    @(posedge clk_sys)
      srst |=> count_q == '0;
  endproperty
  a_reset_clears_count: assert property (p_reset_clears_count) else $error("Reset left counter set.");

endmodule // program_flow_watchdog

// ---- sim/testbench.sv ----
// Self-checking testbench for the program flow watchdog.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk_sys = 1'b0;
  logic        srst = 1'b1;
  logic        power_on_rst = 1'b1;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        lfo_tick = 1'b0;
  logic        bus_tick = 1'b0;
  logic        bdm_active = 1'b0;
  logic        wdog_reset;
  logic        irq;
  int          n_errors = 0;
  int          n_compared = 0;

  always #2.5 clk_sys = ~clk_sys;

  program_flow_watchdog #(.CNT_W(19)) i_program_flow_watchdog (
    .clk_sys(clk_sys), .srst(srst), .power_on_rst(power_on_rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lfo_tick(lfo_tick), .bus_tick(bus_tick), .bdm_active(bdm_active),
    .wdog_reset(wdog_reset), .irq(irq)
  );

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // The master holds the request until pready is seen high; the loop bound only guards a hang.
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int k;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      n_errors++;
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] addr, input logic [31:0] wd);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, addr, wd, rd, err);
  endtask

  task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp, input logic exp_err = 1'b0);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, addr, 32'h0, rd, err);
    chk(rd, exp);
    chk(32'(err), 32'(exp_err));
  endtask

  task automatic settle();
    @(posedge clk_sys);
    #1;
  endtask

  task automatic rst(input logic por);
    @(posedge clk_sys);
    srst <= 1'b1;
    power_on_rst <= por;
    repeat (5) @(posedge clk_sys);
    srst <= 1'b0;
  endtask

  task automatic ticks(input logic bus, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      if (bus) bus_tick <= 1'b1;
      else lfo_tick <= 1'b1;
      @(posedge clk_sys);
      bus_tick <= 1'b0;
      lfo_tick <= 1'b0;
    end
  endtask

  function automatic logic [31:0] opt(input logic en, input logic cs, input logic [2:0] ts);
    return (32'(en) << wdog_pkg::OPT_EN_BIT) | (32'(cs) << wdog_pkg::OPT_CLK_BIT)
         | (32'(ts) << wdog_pkg::OPT_TSEL_LSB);
  endfunction

  task automatic t_reset_values();
    rd_chk(wdog_pkg::OPTIONS_OFFS, opt(1'b1, 1'b0, 3'h7));
    rd_chk(wdog_pkg::CAUSE_OFFS, 32'h0);
    rd_chk(wdog_pkg::INT_MASK_OFFS, 32'h0);
    rd_chk(wdog_pkg::COUNT_OFFS, 32'h0);
    rd_chk(8'h20, 32'h0, 1'b1);
  endtask

  task automatic t_lock_service();
    logic [31:0] locked;
    locked = opt(1'b1, 1'b0, 3'h0) | (32'h1 << wdog_pkg::OPT_LOCK_BIT);
    rst(1'b1);
    wr(wdog_pkg::OPTIONS_OFFS, opt(1'b1, 1'b0, 3'h0));
    wr(wdog_pkg::OPTIONS_OFFS, opt(1'b1, 1'b1, 3'h7));
    rd_chk(wdog_pkg::OPTIONS_OFFS, locked);
    ticks(1'b0, 31);
    rd_chk(wdog_pkg::COUNT_OFFS, 32'd31);
    rd_chk(wdog_pkg::INT_STATUS_OFFS, 32'h2);
    wr(wdog_pkg::CAUSE_OFFS, 32'hFFFFFFFF);
    rd_chk(wdog_pkg::COUNT_OFFS, 32'h0);
    rd_chk(wdog_pkg::CAUSE_OFFS, 32'h0);
    ticks(1'b0, 31);
    settle();
    chk(32'(wdog_reset), 32'h0);
    ticks(1'b0, 1);
    settle();
    chk(32'(wdog_reset), 32'h1);
    rst(1'b0);
    rd_chk(wdog_pkg::CAUSE_OFFS, 32'h1);
    rd_chk(wdog_pkg::COUNT_OFFS, 32'h0);
    rd_chk(wdog_pkg::OPTIONS_OFFS, opt(1'b1, 1'b0, 3'h7));
  endtask

  // One reset per setting, because the options register locks after its first write.
  task automatic run_to(input logic cs, input logic [2:0] ts, input int n);
    rst(1'b1);
    wr(wdog_pkg::OPTIONS_OFFS, opt(1'b1, cs, ts));
    ticks(cs, n - 1);
    repeat (2) settle();
    chk(32'(wdog_reset), 32'h0);
    ticks(cs, 1);
    settle();
    chk(32'(wdog_reset), 32'h1);
  endtask

  task automatic t_timeouts();
    for (int t = 0; t < 8; t++) begin
      run_to(1'b0, 3'(t), 1 << ((t > 5) ? 11 : t + 5));
    end
    for (int t = 0; t < 2; t++) begin
      run_to(1'b1, 3'(t), 1 << (13 + t));
    end
  endtask

  task automatic t_pause();
    rst(1'b1);
    ticks(1'b0, 5);
    rd_chk(wdog_pkg::COUNT_OFFS, 32'd5);
    @(posedge clk_sys);
    bdm_active <= 1'b1;
    ticks(1'b0, 4);
    rd_chk(wdog_pkg::COUNT_OFFS, 32'd5);
    @(posedge clk_sys);
    bdm_active <= 1'b0;
    ticks(1'b1, 4);
    rd_chk(wdog_pkg::COUNT_OFFS, 32'd5);
    wr(wdog_pkg::OPTIONS_OFFS, opt(1'b0, 1'b0, 3'h0));
    ticks(1'b0, 40);
    rd_chk(wdog_pkg::COUNT_OFFS, 32'd5);
    chk(32'(wdog_reset), 32'h0);
  endtask

  task automatic t_irq();
    rst(1'b1);
    wr(wdog_pkg::OPTIONS_OFFS, opt(1'b1, 1'b1, 3'h7));
    ticks(1'b1, 3);
    rd_chk(wdog_pkg::COUNT_OFFS, 32'h3);
    wr(wdog_pkg::INT_STATUS_OFFS, 32'h3);
    wr(wdog_pkg::CAUSE_OFFS, 32'h0);
    rd_chk(wdog_pkg::INT_STATUS_OFFS, 32'h1);
    settle();
    chk(32'(irq), 32'h0);
    wr(wdog_pkg::INT_MASK_OFFS, 32'h1);
    settle();
    chk(32'(irq), 32'h1);
    wr(wdog_pkg::INT_STATUS_OFFS, 32'h1);
    settle();
    chk(32'(irq), 32'h0);
    rd_chk(wdog_pkg::INT_STATUS_OFFS, 32'h0);
  endtask

  initial begin
    repeat (5) @(posedge clk_sys);
    srst <= 1'b0;
    t_reset_values();
    t_lock_service();
    t_pause();
    t_irq();
    t_timeouts();
    conclude();
  end
endmodule // testbench
